/* design/ramp_pkg.sv */
// Shared constants and types for the output-frequency ramp generator
package ramp_pkg;
    // Timing: 200 MHz system clock, 1 ms ramp tick
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RAMP_TICK_US = 1000;
    localparam int RAMP_TICK_CYCLES = (RAMP_TICK_US * 1000000) / CLK_PERIOD_PS;
    // Ticks per stored 0.01 s time unit and per 0.1 s hold unit
    localparam int TICKS_PER_CS = 10;
    localparam int TICKS_PER_DS = 100;
    localparam int FRAC_BITS = 16;

    // Parameter identifiers on the write port
    localparam logic [4:0] ID_ACCEL = 5'h00;
    localparam logic [4:0] ID_DECEL = 5'h01;
    localparam logic [4:0] ID_JOG = 5'h02;
    localparam logic [4:0] ID_ACCEL2 = 5'h03;
    localparam logic [4:0] ID_DECEL2 = 5'h04;
    localparam logic [4:0] ID_RESTART = 5'h05;
    localparam logic [4:0] ID_REF_FREQ = 5'h06;
    localparam logic [4:0] ID_INC_SEL = 5'h07;
    localparam logic [4:0] ID_START_FREQ = 5'h08;
    localparam logic [4:0] ID_HOLD = 5'h09;
    localparam logic [4:0] ID_SWITCH_FREQ = 5'h0a;
    localparam logic [4:0] ID_BASE_FREQ = 5'h0b;
    localparam logic [4:0] ID_CURVE = 5'h0c;
    localparam logic [4:0] ID_MIN_FREQ = 5'h0d;
    localparam logic [4:0] ID_GAIN_A = 5'h0e;
    localparam logic [4:0] ID_GAIN_B = 5'h0f;

    // Written code meaning "no function" (decimal 9999)
    localparam logic [15:0] NONE_CODE = 16'h270f;
    localparam logic [19:0] TIME_NONE = 20'hfffff;
    localparam logic [15:0] FREQ_NONE = 16'hffff;
    // Limits, 0.01 s for times, 0.01 Hz for frequencies, 0.1 s for hold
    localparam logic [19:0] TIME_MAX_CS = 20'h57e40;
    localparam logic [19:0] TIME_MIN_CS = 20'h00003;
    localparam logic [19:0] TIME_FLOOR_CS = 20'h00004;
    localparam logic [15:0] START_FREQ_MAX = 16'h1770;
    localparam logic [15:0] FREQ_MAX = 16'h9c40;
    localparam logic [15:0] REF_FREQ_MIN = 16'h0064;
    localparam logic [15:0] HOLD_MAX_DS = 16'h0064;
    localparam logic [19:0] TEN_20 = 20'h0000a;
    // Reset values
    localparam logic [15:0] REF_FREQ_RST = 16'h1388;
    localparam logic [15:0] START_FREQ_RST = 16'h0032;
    localparam logic [15:0] BASE_FREQ_RST = 16'h1388;
    localparam logic [19:0] TIME_RST_CS = 20'h001f4;
    localparam logic [1:0] CURVE_LINEAR = 2'h0;
    localparam logic [1:0] CURVE_S_A = 2'h1;

    typedef struct packed {
        logic [19:0] accel;
        logic [19:0] decel;
        logic [19:0] jog;
        logic [19:0] accel2;
        logic [19:0] decel2;
        logic [19:0] restart;
        logic [15:0] refFreq;
        logic incSel;
        logic [15:0] startFreq;
        logic [15:0] hold;
        logic [15:0] switchFreq;
        logic [15:0] baseFreq;
        logic [1:0] curve;
        logic [15:0] minFreq;
        logic [15:0] gainA;
        logic [15:0] gainB;
    } param_t;

    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_HOLD = 3'b010,
        ST_RUN = 3'b100
    } ramp_state_t;
endpackage

/* design/drive_frequency_ramp_control.sv */
// Output-frequency ramp generator with two time sets and start gating
`timescale 1ns/100ps

// Summary of operation
// - Acceleration slope takes the selected time from 0 Hz to reference.
// - Deceleration slope takes the selected time from reference to 0 Hz.
// - Reset gives reference 50 Hz and starting frequency 0.5 Hz.
// - Increment change keeps digits of normal, jog, second times; unit shifts.
// - Restart acceleration time is never rescaled by increment change.
// - Second times apply when select input on or output at threshold.
// - Second deceleration code 9999 means use second acceleration time.
// - Threshold 9999 disables automatic switching.
// - Threshold 0 Hz switches to second times at the first tick after start.
// - Below threshold first pair, at or above threshold second pair.
// - Threshold above set frequency keeps the first pair.
// - Select input switches to second pair at the next tick, below threshold too.
// - S-curve A time to f above base is 4/9 T f^2/fb^2 + 5/9 T.
// - Times of 0.03 s or less run as 0.04 s.
// - Writing reference frequency leaves analog gain frequencies alone.
// - Starting frequency accepts 0 to 60 Hz, applied at start.
// - Start-hold accepts 0.0 to 10.0 s; 9999 disables hold.
// - Start at starting frequency when start on and command reaches it.
// - Stay stopped while command is below starting frequency.
// - Starting below minimum lets start alone run at minimum frequency.
// - Increment 0 gives 0.1 s, 0-3600 s; 1 gives 0.01 s, 0-655.35 s.
// - Hold starting frequency for the hold time before ramping.
// - Start removed during hold decelerates from there at once.
module drive_frequency_ramp_control #(
    parameter int TICK_CYCLES = ramp_pkg::RAMP_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic startPin,
    input wire logic second_set_select,
    input wire logic jogMode,
    input wire logic [15:0] cmdFreq,
    input wire logic paramWe,
    input wire logic [4:0] paramId,
    input wire logic [15:0] paramData,
    output logic [15:0] outFreq,
    output logic running,
    output logic holding,
    output logic secondActive,
    output logic [15:0] analog_gain_freq_a,
    output logic [15:0] analog_gain_freq_b
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a change counts once stages two and three agree
    logic [2:0] startSync_q, startSync_d, selSync_q, selSync_d;
    logic startOn_q, startOn_d, selOn_q, selOn_d;
    always_comb begin
        startSync_d = {startSync_q[1:0], startPin};
        selSync_d = {selSync_q[1:0], second_set_select};
        startOn_d = (startSync_q[1] == startSync_q[2]) ?
            startSync_q[2] : startOn_q;
        selOn_d = (selSync_q[1] == selSync_q[2]) ? selSync_q[2] : selOn_q;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            {startSync_q, selSync_q, startOn_q, selOn_q} <= 8'h00;
        end else begin
            {startSync_q, selSync_q, startOn_q, selOn_q} <=
                {startSync_d, selSync_d, startOn_d, selOn_d};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parameter store; times kept internally in 0.01 s
    ramp_pkg::param_t param_q, param_d;
    // Written time digits to 0.01 s, keeping the no-function code
    function automatic logic [19:0] timeIn(input logic [15:0] data,
                                           input logic inc,
                                           input logic allowNone);
        logic [19:0] cs;
        cs = inc ? {4'h0, data} : 20'({4'h0, data} * ramp_pkg::TEN_20);
        if (allowNone && data == ramp_pkg::NONE_CODE) begin
            timeIn = ramp_pkg::TIME_NONE;
        end else if (cs > ramp_pkg::TIME_MAX_CS) begin
            timeIn = ramp_pkg::TIME_MAX_CS;
        end else begin
            timeIn = cs;
        end
    endfunction
    // Same digits in the new unit: finer divides by ten, coarser multiplies
    function automatic logic [19:0] rescale(input logic [19:0] t,
                                            input logic toFine);
        logic [23:0] up;
        up = 24'({4'h0, t} * 24'(ramp_pkg::TEN_20));
        if (t == ramp_pkg::TIME_NONE) begin
            rescale = t;
        end else if (toFine) begin
            rescale = t / ramp_pkg::TEN_20;
        end else if (up > 24'(ramp_pkg::TIME_MAX_CS)) begin
            rescale = ramp_pkg::TIME_MAX_CS;
        end else begin
            rescale = up[19:0];
        end
    endfunction
    function automatic logic [15:0] freqIn(input logic [15:0] data,
                                           input logic [15:0] maxF);
        freqIn = (data > maxF) ? maxF : data;
    endfunction
    always_comb begin
        param_d = param_q;
        if (paramWe) begin
            unique case (paramId)
                ramp_pkg::ID_ACCEL:
                    param_d.accel = timeIn(paramData, param_q.incSel, 1'b0);
                ramp_pkg::ID_DECEL:
                    param_d.decel = timeIn(paramData, param_q.incSel, 1'b0);
                ramp_pkg::ID_JOG:
                    param_d.jog = timeIn(paramData, param_q.incSel, 1'b0);
                ramp_pkg::ID_ACCEL2:
                    param_d.accel2 = timeIn(paramData, param_q.incSel, 1'b0);
                ramp_pkg::ID_DECEL2:
                    param_d.decel2 = timeIn(paramData, param_q.incSel, 1'b1);
                ramp_pkg::ID_RESTART:
                    param_d.restart = timeIn(paramData, param_q.incSel, 1'b0);
                ramp_pkg::ID_REF_FREQ: begin
                    // Gain frequencies deliberately stay put
                    param_d.refFreq = (paramData < ramp_pkg::REF_FREQ_MIN) ?
                        ramp_pkg::REF_FREQ_MIN :
                        freqIn(paramData, ramp_pkg::FREQ_MAX);
                end
                ramp_pkg::ID_INC_SEL: begin
                    param_d.incSel = paramData[0];
                    if (paramData[0] != param_q.incSel) begin
                        param_d.accel = rescale(param_q.accel, paramData[0]);
                        param_d.decel = rescale(param_q.decel, paramData[0]);
                        param_d.jog = rescale(param_q.jog, paramData[0]);
                        param_d.accel2 = rescale(param_q.accel2, paramData[0]);
                        param_d.decel2 = rescale(param_q.decel2, paramData[0]);
                        // Restart time keeps its seconds
                    end
                end
                ramp_pkg::ID_START_FREQ:
                    param_d.startFreq =
                        freqIn(paramData, ramp_pkg::START_FREQ_MAX);
                ramp_pkg::ID_HOLD:
                    param_d.hold = (paramData == ramp_pkg::NONE_CODE) ?
                        ramp_pkg::FREQ_NONE :
                        freqIn(paramData, ramp_pkg::HOLD_MAX_DS);
                ramp_pkg::ID_SWITCH_FREQ:
                    param_d.switchFreq = (paramData == ramp_pkg::NONE_CODE) ?
                        ramp_pkg::FREQ_NONE :
                        freqIn(paramData, ramp_pkg::FREQ_MAX);
                ramp_pkg::ID_BASE_FREQ:
                    param_d.baseFreq = (paramData < ramp_pkg::REF_FREQ_MIN) ?
                        ramp_pkg::REF_FREQ_MIN :
                        freqIn(paramData, ramp_pkg::FREQ_MAX);
                ramp_pkg::ID_CURVE: param_d.curve = paramData[1:0];
                ramp_pkg::ID_MIN_FREQ:
                    param_d.minFreq = freqIn(paramData, ramp_pkg::FREQ_MAX);
                ramp_pkg::ID_GAIN_A: param_d.gainA = paramData;
                ramp_pkg::ID_GAIN_B: param_d.gainB = paramData;
                default: ;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            param_q <= '0;
            param_q.accel <= ramp_pkg::TIME_RST_CS;
            param_q.decel <= ramp_pkg::TIME_RST_CS;
            param_q.jog <= ramp_pkg::TIME_RST_CS;
            param_q.accel2 <= ramp_pkg::TIME_RST_CS;
            param_q.decel2 <= ramp_pkg::TIME_NONE;
            param_q.restart <= ramp_pkg::TIME_RST_CS;
            param_q.refFreq <= ramp_pkg::REF_FREQ_RST;
            param_q.startFreq <= ramp_pkg::START_FREQ_RST;
            param_q.hold <= ramp_pkg::FREQ_NONE;
            param_q.switchFreq <= ramp_pkg::FREQ_NONE;
            param_q.baseFreq <= ramp_pkg::BASE_FREQ_RST;
        end else begin
            param_q <= param_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ramp tick divider
    logic [31:0] tickCnt_q, tickCnt_d;
    logic tick;
    always_comb begin
        tick = (tickCnt_q == 32'(TICK_CYCLES - 1));
        tickCnt_d = tick ? 32'h0 : tickCnt_q + 32'h1;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            tickCnt_q <= 32'h0;
        end else begin
            tickCnt_q <= tickCnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start gating, hold and ramp state
    ramp_pkg::ramp_state_t state_q, state_d;
    logic [31:0] freqFx_q, freqFx_d;
    logic [19:0] holdCnt_q, holdCnt_d;
    logic second_q, second_d;
    logic belowMin, cmdOk, driveOn, up;
    logic [15:0] target, freqNow;
    logic [19:0] selT, baseT;
    logic [63:0] sq, effT, stepFx, refUse;
    logic [31:0] targetFx;
    always_comb begin
        freqNow = freqFx_q[31:ramp_pkg::FRAC_BITS];
        belowMin = param_q.startFreq < param_q.minFreq;
        // Start alone is enough below the minimum
        cmdOk = (cmdFreq >= param_q.startFreq) || belowMin;
        driveOn = startOn_q && cmdOk;
        target = 16'h0;
        if (driveOn) begin
            target = (cmdFreq < param_q.minFreq) ? param_q.minFreq : cmdFreq;
        end
        targetFx = {target, 16'h0};
        up = targetFx > freqFx_q;
        // Select input wins at the next tick; threshold 9999 never fires
        second_d = second_q;
        if (tick) begin
            second_d = selOn_q ||
                (param_q.switchFreq != ramp_pkg::FREQ_NONE &&
                 freqNow >= param_q.switchFreq);
        end
        // Time pair choice; jog uses one time both ways
        if (jogMode) begin
            selT = param_q.jog;
        end else if (second_q) begin
            selT = up ? param_q.accel2 :
                (param_q.decel2 == ramp_pkg::TIME_NONE) ?
                param_q.accel2 : param_q.decel2;
        end else begin
            selT = up ? param_q.accel : param_q.decel;
        end
        baseT = (selT <= ramp_pkg::TIME_MIN_CS) ?
            ramp_pkg::TIME_FLOOR_CS : selT;
        // S-curve A scales time from base frequency to target
        refUse = 64'(param_q.refFreq);
        effT = 64'(baseT);
        sq = 64'(target) * 64'(target);
        if (param_q.curve == ramp_pkg::CURVE_S_A && target != 16'h0) begin
            refUse = 64'(target);
            if (target >= param_q.baseFreq) begin
                effT = (64'h4 * 64'(baseT) * sq /
                        (64'(param_q.baseFreq) * 64'(param_q.baseFreq)) +
                        64'h5 * 64'(baseT)) / 64'h9;
            end else begin
                effT = 64'(baseT) * 64'(target) / 64'(param_q.baseFreq);
            end
            effT = (effT == 64'h0) ? 64'h1 : effT;
        end
        // Step per tick in 0.01 Hz with 16 fraction bits
        stepFx = (refUse << ramp_pkg::FRAC_BITS) /
            (effT * 64'(ramp_pkg::TICKS_PER_CS));
        // Never a zero step, or a long time would stall the ramp
        stepFx = (stepFx == 64'h0) ? 64'h1 : stepFx;
        state_d = state_q;
        freqFx_d = freqFx_q;
        holdCnt_d = holdCnt_q;
        unique case (state_q)
            ramp_pkg::ST_STOP: begin
                freqFx_d = 32'h0;
                second_d = 1'b0;
                if (driveOn) begin
                    freqFx_d = {param_q.startFreq, 16'h0};
                    if (param_q.hold != ramp_pkg::FREQ_NONE &&
                        param_q.hold != 16'h0) begin
                        state_d = ramp_pkg::ST_HOLD;
                        holdCnt_d = 20'(param_q.hold *
                                        16'(ramp_pkg::TICKS_PER_DS));
                    end else begin
                        state_d = ramp_pkg::ST_RUN;
                    end
                end
            end
            ramp_pkg::ST_HOLD: begin
                if (!startOn_q) begin
                    state_d = ramp_pkg::ST_RUN;
                end else if (tick) begin
                    holdCnt_d = holdCnt_q - 20'h1;
                    if (holdCnt_q == 20'h1) begin
                        state_d = ramp_pkg::ST_RUN;
                    end
                end
            end
            ramp_pkg::ST_RUN: begin
                if (tick) begin
                    // Clamp so the step never overshoots
                    if (up) begin
                        freqFx_d = (targetFx - freqFx_q < stepFx[31:0]) ?
                            targetFx : freqFx_q + stepFx[31:0];
                    end else begin
                        freqFx_d = (freqFx_q - targetFx < stepFx[31:0]) ?
                            targetFx : freqFx_q - stepFx[31:0];
                    end
                end
                if (target == 16'h0 && freqFx_q == 32'h0) begin
                    state_d = ramp_pkg::ST_STOP;
                end
            end
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_q <= ramp_pkg::ST_STOP;
            freqFx_q <= 32'h0;
            holdCnt_q <= 20'h0;
            second_q <= 1'b0;
        end else begin
            state_q <= state_d;
            freqFx_q <= freqFx_d;
            holdCnt_q <= holdCnt_d;
            second_q <= second_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            {outFreq, running, holding, secondActive, analog_gain_freq_a,
             analog_gain_freq_b} <= '0;
        end else begin
            outFreq <= freqFx_d[31:ramp_pkg::FRAC_BITS];
            running <= state_d != ramp_pkg::ST_STOP;
            holding <= state_d == ramp_pkg::ST_HOLD;
            secondActive <= second_d;
            analog_gain_freq_a <= param_d.gainA;
            analog_gain_freq_b <= param_d.gainB;
        end
    end

endmodule

/* dv/ramp_host_model.sv */
// Host parameter writer and modulation-stage partner for the ramp bench
`timescale 1ns/100ps
module ramp_host_model (
    input wire logic sys_clk,
    input wire logic [15:0] outFreq,
    output logic paramWe,
    output logic [4:0] paramId,
    output logic [15:0] paramData
);
    logic [15:0] lastFreq;

    // Idle write port; the select pin is taken as already mapped
    initial begin
        paramWe = 1'b0;
        paramId = 5'h1f;
        paramData = 16'h0000;
    end

    // One-cycle strobe; released fields show the inverse, not a stale value
    task automatic write_param(input logic [4:0] id, input logic [15:0] d);
        @(posedge sys_clk);
        #1;
        paramWe = 1'b1;
        paramId = id;
        paramData = d;
        @(posedge sys_clk);
        #1;
        paramWe = 1'b0;
        paramId = ~id;
        paramData = ~d;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Modulation stage only consumes the frequency word once per clock
    always @(posedge sys_clk) begin
        lastFreq <= outFreq;
    end
endmodule

/* dv/drive_frequency_ramp_control_chk.sv */
// Port-level assertions for the output-frequency ramp generator
`timescale 1ns/100ps
module drive_frequency_ramp_control_chk #(
    parameter int TICK_CYCLES = ramp_pkg::RAMP_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic startPin,
    input wire logic second_set_select,
    input wire logic jogMode,
    input wire logic [15:0] cmdFreq,
    input wire logic paramWe,
    input wire logic [4:0] paramId,
    input wire logic [15:0] paramData,
    input wire logic [15:0] outFreq,
    input wire logic running,
    input wire logic holding,
    input wire logic secondActive,
    input wire logic [15:0] analog_gain_freq_a,
    input wire logic [15:0] analog_gain_freq_b
);
    // Pin sync plus one tick plus the selection register
    localparam int SEL_LIMIT = TICK_CYCLES + 8;
    logic [31:0] selCnt_q;
    logic [31:0] selCnt_d;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Cycles the select pin has waited for the second pair while running
    always_comb begin
        selCnt_d = 32'h00000000;
        if (running && second_set_select && !secondActive) begin
            selCnt_d = selCnt_q + 32'h00000001;
        end
    end
    always_ff @(posedge sys_clk) begin
        selCnt_q <= rst_b ? selCnt_d : 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Steps of multi-cycle behaviour
    sequence refWrite;
        !$past(paramWe) && paramWe && paramId == ramp_pkg::ID_REF_FREQ
            ##1 !paramWe;
    endsequence
    sequence gainWrite;
        paramWe && paramId == ramp_pkg::ID_GAIN_A
            && paramData <= ramp_pkg::FREQ_MAX ##1 !paramWe;
    endsequence

    a_stop_zero: assert property (!running |-> outFreq == 16'h0000)
        else $error("output frequency nonzero while stopped");
    a_hold_running: assert property (holding |-> running)
        else $error("hold flagged while stopped");
    a_hold_stable: assert property (holding && $past(holding) |-> $stable(outFreq))
        else $error("output moved during start hold");
    a_step_spacing: assert property ($changed(outFreq) && running
        && $past(running) && outFreq != 16'h0000 |=> $stable(outFreq) [*8])
        else $error("output stepped twice within one tick");
    a_select_wait: assert property (selCnt_q <= 32'(SEL_LIMIT))
        else $error("select pin did not switch to second pair");
    a_ref_keeps_gain: assert property (refWrite |=>
        $stable(analog_gain_freq_a) && $stable(analog_gain_freq_b) [*2])
        else $error("reference write disturbed gain frequency");
    a_gain_write: assert property (gainWrite |=>
        analog_gain_freq_a == $past(paramData, 2))
        else $error("gain frequency write not stored");
    a_hold_abort: assert property (holding && !startPin [*3]
        |-> ##[0:5] !holding)
        else $error("start removal did not end the hold");
    a_second_idle: assert property (!running && $past(!running)
        |-> !secondActive)
        else $error("second pair flagged while stopped");
endmodule

bind drive_frequency_ramp_control drive_frequency_ramp_control_chk #(
    .TICK_CYCLES(TICK_CYCLES)
) u_chk (.sys_clk, .rst_b, .startPin, .second_set_select, .jogMode,
    .cmdFreq, .paramWe, .paramId, .paramData, .outFreq, .running, .holding,
    .secondActive, .analog_gain_freq_a, .analog_gain_freq_b);

/* dv/tb.sv */
// Self-checking bench for the output-frequency ramp generator
`timescale 1ns/100ps
module tb;
    // Short tick keeps ramps of hundreds of steps inside the run budget
    localparam int TICK = 20;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic startPin = 1'b0;
    logic second_set_select = 1'b0;
    logic [15:0] cmdFreq = 16'h0000;
    logic paramWe;
    logic [4:0] paramId;
    logic [15:0] paramData;
    logic [15:0] outFreq;
    logic running;
    logic holding;
    logic secondActive;
    logic [15:0] gainA;
    logic [15:0] gainB;
    int n_fail = 0;
    int n_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    drive_frequency_ramp_control #(.TICK_CYCLES(TICK)) u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .startPin(startPin),
        .second_set_select(second_set_select), .jogMode(1'b0),
        .cmdFreq(cmdFreq), .paramWe(paramWe), .paramId(paramId),
        .paramData(paramData), .outFreq(outFreq), .running(running),
        .holding(holding), .secondActive(secondActive),
        .analog_gain_freq_a(gainA), .analog_gain_freq_b(gainB));
    ramp_host_model u_host (.sys_clk(sys_clk), .outFreq(outFreq),
        .paramWe(paramWe), .paramId(paramId), .paramData(paramData));

    ////////////////////////////////////////////////////////////////////////
    // Comparison, timing and drive helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] id, input logic [15:0] d);
        u_host.write_param(id, d);
    endtask
    task automatic wait_run(input logic lvl);
        int k;
        k = 0;
        while (running !== lvl && k < 50000) begin
            cyc(1);
            k++;
        end
        chk_bit(running, lvl);
    endtask
    task automatic run(input logic [15:0] cmd);
        cmdFreq = cmd;
        startPin = 1'b1;
        wait_run(1'b1);
    endtask
    task automatic stop();
        startPin = 1'b0;
        wait_run(1'b0);
    endtask
    // Total change over n ticks, counted from a tick edge
    task automatic slope(input int n, input logic [15:0] total);
        logic [15:0] v;
        int k;
        k = 0;
        v = outFreq;
        while (outFreq === v && k < 100) begin
            cyc(1);
            k++;
        end
        v = outFreq;
        cyc(n * TICK);
        chk(outFreq - v, total);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Test sequence; 5000 = 50 Hz reference, 1.0 s accel gives 5 per tick
    initial begin
        cyc(20);
        rst_b = 1'b1;
        chk(outFreq, 16'h0000);
        cmdFreq = 16'h0031;
        startPin = 1'b1;
        cyc(40);
        chk_bit(running, 1'b0);
        run(16'h0032);
        chk(outFreq, 16'h0032);
        stop();
        $display("test start gating done");
        wr(ramp_pkg::ID_ACCEL, 16'h000a);
        wr(ramp_pkg::ID_DECEL, 16'h0014);
        wr(ramp_pkg::ID_ACCEL2, 16'h0014);
        run(16'h0fa0);
        slope(10, 16'h0032);
        chk_bit(secondActive, 1'b0);
        startPin = 1'b0;
        cyc(8);
        slope(10, 16'hffe7);
        stop();
        second_set_select = 1'b1;
        run(16'h0fa0);
        cyc(TICK + 8);
        chk_bit(secondActive, 1'b1);
        slope(10, 16'h0019);
        startPin = 1'b0;
        cyc(8);
        slope(10, 16'hffe7);
        stop();
        second_set_select = 1'b0;
        cyc(8);
        chk_bit(secondActive, 1'b0);
        $display("test slopes and select pin done");
        wr(ramp_pkg::ID_SWITCH_FREQ, 16'h0000);
        run(16'h0fa0);
        cyc(TICK + 8);
        chk_bit(secondActive, 1'b1);
        stop();
        wr(ramp_pkg::ID_SWITCH_FREQ, 16'h0fa1);
        run(16'h0fa0);
        cyc(2 * TICK);
        chk_bit(secondActive, 1'b0);
        stop();
        wr(ramp_pkg::ID_SWITCH_FREQ, 16'h0064);
        run(16'h0fa0);
        cyc(4);
        chk_bit(secondActive, 1'b0);
        cyc(14 * TICK);
        chk_bit(secondActive, 1'b1);
        stop();
        wr(ramp_pkg::ID_SWITCH_FREQ, ramp_pkg::NONE_CODE);
        $display("test switching threshold done");
        // Finer unit: 10 digits now mean 0.10 s, 50 per tick
        wr(ramp_pkg::ID_INC_SEL, 16'h0001);
        run(16'h0fa0);
        slope(2, 16'h0064);
        wr(ramp_pkg::ID_ACCEL, 16'h0003);
        slope(2, 16'h00fa);
        stop();
        wr(ramp_pkg::ID_MIN_FREQ, 16'h0064);
        run(16'h0000);
        cyc(3 * TICK);
        chk(outFreq, 16'h0064);
        stop();
        wr(ramp_pkg::ID_MIN_FREQ, 16'h0000);
        $display("test increment and minimum done");
        wr(ramp_pkg::ID_HOLD, 16'h0001);
        run(16'h0fa0);
        cyc(20 * TICK);
        chk_bit(holding, 1'b1);
        chk(outFreq, 16'h0032);
        startPin = 1'b0;
        cyc(8);
        chk_bit(holding, 1'b0);
        stop();
        $display("test start hold done");
        wr(ramp_pkg::ID_GAIN_A, 16'h1234);
        wr(ramp_pkg::ID_GAIN_B, 16'h0abc);
        wr(ramp_pkg::ID_REF_FREQ, 16'h1770);
        cyc(3);
        chk(gainA, 16'h1234);
        chk(gainB, 16'h0abc);
        // Curve A to base at 60 Hz reference: base sets the slope, 125/tick
        wr(ramp_pkg::ID_HOLD, ramp_pkg::NONE_CODE);
        wr(ramp_pkg::ID_CURVE, 16'h0001);
        run(16'h1388);
        slope(2, 16'h00fa);
        stop();
        $display("test gain and curve done");
        final_report();
    end

    // Watchdog well beyond the expected run of some 7000 cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_fail++;
        final_report();
    end
endmodule
